/* hdl/dorpc_pkg.sv */
// Package: constants and carrier types for the drive option control block
package dorpc_pkg;

  // Option function codes
  localparam logic [3:0] OPT_NONE = 4'h1;
  localparam logic [3:0] OPT_PRESET_SPEED_ENABLE_RAMP = 4'h2;
  localparam logic [3:0] OPT_PATTERN = 4'h3;
  localparam logic [3:0] OPT_TRAVERSE = 4'h4;
  localparam logic [3:0] OPT_PID = 4'h5;
  localparam logic [3:0] OPT_PUMP_A = 4'h6;
  localparam logic [3:0] OPT_PUMP_B = 4'h7;
  localparam logic [3:0] OPT_PUMP_C = 4'h8;

  // Step decode styles and spans
  localparam logic [1:0] STYLE_BINARY = 2'h1;
  localparam logic [1:0] STYLE_ONEHOT = 2'h2;
  localparam logic [1:0] SPAN_10V = 2'h1;
  localparam logic [1:0] SPAN_5V = 2'h2;

  // Loop behaviour digits
  localparam logic [1:0] RUN_COND_BOTH = 2'h1;
  localparam logic [1:0] RUN_COND_ENABLE = 2'h2;
  localparam logic [1:0] STOP_NEVER = 2'h1;
  localparam logic [1:0] STOP_AT_LOW = 2'h2;

  // Output selection codes
  localparam logic [4:0] SEL_LOW_BOUND = 5'h18;
  localparam logic [4:0] SEL_HIGH_BOUND = 5'h19;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIMITS = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_TIME = 8'h0c;
  localparam logic [7:0] ADDR_SETPT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_OUTSEL = 8'h18;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_2211;
  localparam logic [31:0] LIMITS_RST = 32'h0000_ffff;
  localparam logic [31:0] TIME_RST = 32'h0000_0100;

  // Scaling: 100 percent in Q16 units is 16'hffff
  localparam logic [15:0] FULL_SCALE = 16'hffff;
  localparam int SYNC_STAGES = 3;

  // Step input bundle from the terminals
  typedef struct packed {
    logic upper_bank_choose;
    logic step_bit_three;
    logic step_bit_two;
    logic step_bit_one;
    logic step_bit_zero;
  } dorpc_steps_t;

  // Sequence command bundle
  typedef struct packed {
    logic preset_speed_enable;
    logic alternate_ramp_input;
    logic loop_enable_input;
    logic local_panel_flag;
    logic run_cmd;
    logic jog_cmd;
    logic brake_cmd;
  } dorpc_seq_t;

  // Ramp selection result
  typedef struct packed {
    logic alt_ramp;
    logic [2:0] pair;
    logic speed_change;
  } dorpc_ramp_t;

  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_RUN = 2'b01,
    DRV_AUTO_STOP = 2'b11,
    DRV_LATCH_STOP = 2'b10
  } dorpc_drv_t;

endpackage

/* hdl/dorpc_top.sv */
// Top: option selection, ramp step decode, PID gating and supervision
// Function
// R1 - Exactly one option function from code
// R2 - Binary style: three bits pick pair
// R3 - One-hot style: bank bit picks upper half
// R4 - Invalid one-hot keeps previous, zero initially
// R5 - Preset speed off: ramp times only
// R6 - Alternate ramp input overrides program ramp
// R7 - PID only in remote operation
// R8 - Jog or brake never start PID
// R9 - Loop enable input gates PID
// R10 - Hertz setpoint converted to percent
// R11 - Third input scaled 10V or 5V
// R12 - Bound flags routed on codes 24, 25
// R13 - Feedback loss trip after determination time
// R14 - Error polarity inverts on request
// R15 - Run condition: enable+run or enable
// R16 - Auto stop option at lower limiter
// R17 - Setting 21 latches stop until RUN cycles
// R18 - Setting 22 restarts above limiter plus hysteresis
// R19 - Inputs synchronised, decoded every cycle
`timescale 1ns/1ps
module dorpc_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequence terminals
  input wire dorpc_pkg::dorpc_steps_t steps_in,
  input wire dorpc_pkg::dorpc_seq_t seq_in,
  // Analog feedback and command
  input wire logic [15:0] feedback_raw,
  input wire logic [15:0] third_analog_input,
  input wire logic feedback_is_third,
  input wire logic [15:0] pid_output,
  // Option enables, one-hot by code
  output logic [7:0] option_active,
  // Ramp and frequency command path
  output dorpc_pkg::dorpc_ramp_t ramp_sel,
  output logic [15:0] setpoint_pct,
  output logic signed [16:0] pid_error,
  output logic pid_running,
  output logic drive_run,
  output logic high_bound_flag,
  output logic low_bound_flag,
  output logic [1:0] preset_speed_enable_outputs,
  output logic feedback_fault_trip
);

  // Width of the synchronised terminal bundle
  localparam int SYNC_W = 12;
  logic rst_m_r;
  logic rst_n_r;
  logic [31:0] ctrl_r;
  logic [31:0] limits_r;
  logic [31:0] fault_r;
  logic [31:0] time_r;
  logic [31:0] setpt_r;
  logic [9:0] outsel_r;
  logic [SYNC_W-1:0] sync_a_r;
  logic [SYNC_W-1:0] sync_b_r;
  logic [SYNC_W-1:0] sync_c_r;
  logic [SYNC_W-1:0] in_r;
  logic [2:0] pair_r;
  logic [15:0] dwell_r;
  logic run_prev_r;
  dorpc_pkg::dorpc_drv_t drv_r;
  dorpc_pkg::dorpc_drv_t drv_nxt;

  // Control register fields
  logic [3:0] opt_code;
  logic [1:0] style;
  logic [1:0] span;
  logic [1:0] run_cond;
  logic [1:0] stop_opt;
  logic invert;
  logic sp_hz;
  assign opt_code = ctrl_r[3:0];
  assign style = ctrl_r[5:4];
  assign span = ctrl_r[9:8];
  assign run_cond = ctrl_r[13:12];
  assign stop_opt = ctrl_r[15:14];
  assign invert = ctrl_r[16];
  assign sp_hz = ctrl_r[17];

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // Three-stage synchroniser, accept on agreement
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      sync_a_r <= '0;
      sync_b_r <= '0;
      sync_c_r <= '0;
      in_r <= '0;
    end
    else
    begin
      sync_a_r <= {steps_in, seq_in}; // R19
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
      for (int i = 0; i < SYNC_W; i++)
      begin
        if (sync_b_r[i] == sync_c_r[i])
          in_r[i] <= sync_c_r[i];
      end
    end
  end

  dorpc_pkg::dorpc_steps_t st;
  dorpc_pkg::dorpc_seq_t sq;
  assign st = in_r[11:7];
  assign sq = in_r[6:0];

  // APB register writes
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ctrl_r <= dorpc_pkg::CTRL_RST;
      limits_r <= dorpc_pkg::LIMITS_RST;
      fault_r <= '0;
      time_r <= dorpc_pkg::TIME_RST;
      setpt_r <= '0;
      outsel_r <= '0;
    end
    else if (psel && penable && pwrite)
    begin
      case (paddr)
        dorpc_pkg::ADDR_CTRL: ctrl_r <= pwdata;
        dorpc_pkg::ADDR_LIMITS: limits_r <= pwdata;
        dorpc_pkg::ADDR_FAULT: fault_r <= pwdata;
        dorpc_pkg::ADDR_TIME: time_r <= pwdata;
        dorpc_pkg::ADDR_SETPT: setpt_r <= pwdata;
        dorpc_pkg::ADDR_OUTSEL: outsel_r <= pwdata[9:0];
        default: ;
      endcase
    end
  end

  // APB read data and response
  assign pready = 1'b1;
  always_comb
  begin
    pslverr = 1'b0;
    prdata = '0;
    case (paddr)
      dorpc_pkg::ADDR_CTRL: prdata = ctrl_r;
      dorpc_pkg::ADDR_LIMITS: prdata = limits_r;
      dorpc_pkg::ADDR_FAULT: prdata = fault_r;
      dorpc_pkg::ADDR_TIME: prdata = time_r;
      dorpc_pkg::ADDR_SETPT: prdata = setpt_r;
      dorpc_pkg::ADDR_OUTSEL: prdata = {22'h0, outsel_r};
      dorpc_pkg::ADDR_STATUS:
        prdata = {23'h0, feedback_fault_trip, low_bound_flag,
                  high_bound_flag, drv_r, pid_running, pair_r};
      default: pslverr = psel & penable;
    endcase
  end

  // Option decode, one bit per legal code
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      option_active <= 8'h01;
    else if (opt_code >= dorpc_pkg::OPT_NONE
             && opt_code <= dorpc_pkg::OPT_PUMP_C)
      option_active <= 8'h01 << (opt_code - 4'h1); // R1
    else
      option_active <= 8'h01;
  end

  // One-hot step validity
  logic [3:0] hot;
  logic hot_ok;
  logic [1:0] hot_idx;
  assign hot = {st.step_bit_three, st.step_bit_two, st.step_bit_one,
                st.step_bit_zero};
  assign hot_ok = (hot != 4'h0) && ((hot & (hot - 4'h1)) == 4'h0);
  always_comb
  begin
    case (hot)
      4'h2: hot_idx = 2'h1;
      4'h4: hot_idx = 2'h2;
      4'h8: hot_idx = 2'h3;
      default: hot_idx = 2'h0;
    endcase
  end

  // Ramp pair selection and hold
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      pair_r <= 3'h0; // R4
    else if (style == dorpc_pkg::STYLE_BINARY)
      pair_r <= {st.step_bit_two, st.step_bit_one, st.step_bit_zero}; // R2
    else if (style == dorpc_pkg::STYLE_ONEHOT && hot_ok)
      pair_r <= {st.upper_bank_choose, hot_idx}; // R3 R4
  end

  // Ramp output toward ramp path
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ramp_sel <= '0;
    else
    begin
      ramp_sel.alt_ramp <= sq.alternate_ramp_input; // R6
      ramp_sel.pair <= option_active[1] ? pair_r : 3'h0;
      ramp_sel.speed_change <= option_active[1]
                               & sq.preset_speed_enable; // R5
    end
  end

  // Feedback scaling for third input
  logic [15:0] fb;
  always_comb
  begin
    if (!feedback_is_third)
      fb = feedback_raw;
    else if (span == dorpc_pkg::SPAN_5V)
      fb = third_analog_input[15] ? dorpc_pkg::FULL_SCALE
                                  : {third_analog_input[14:0], 1'b0}; // R11
    else
      fb = third_analog_input; // R11
  end

  // Setpoint in percent, hertz scaled by max frequency
  logic [15:0] cmd;
  logic [31:0] hz_prod;
  assign hz_prod = setpt_r[15:0] * dorpc_pkg::FULL_SCALE;
  always_comb
  begin
    if (sp_hz && setpt_r[31:16] != 16'h0)
      cmd = (setpt_r[15:0] >= setpt_r[31:16]) ? dorpc_pkg::FULL_SCALE
            : 16'(hz_prod / {16'h0, setpt_r[31:16]}); // R10
    else
      cmd = setpt_r[15:0];
  end

  // Error polarity and limit flags
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      setpoint_pct <= '0;
      pid_error <= '0;
      high_bound_flag <= 1'b0;
      low_bound_flag <= 1'b0;
      preset_speed_enable_outputs <= '0;
    end
    else
    begin
      setpoint_pct <= cmd;
      pid_error <= invert ? ($signed({1'b0, fb}) - $signed({1'b0, cmd}))
                          : ($signed({1'b0, cmd}) - $signed({1'b0, fb})); // R14
      high_bound_flag <= fb > limits_r[15:0]; // R12
      low_bound_flag <= fb < limits_r[31:16]; // R12
      for (int k = 0; k < 2; k++)
        preset_speed_enable_outputs[k] <=
          (outsel_r[5*k +: 5] == dorpc_pkg::SEL_LOW_BOUND) ? low_bound_flag
          : (outsel_r[5*k +: 5] == dorpc_pkg::SEL_HIGH_BOUND)
            ? high_bound_flag : 1'b0; // R12
    end
  end

  // Feedback loss determination timer
  logic loss;
  assign loss = cmd >= fault_r[15:0] && fb <= fault_r[31:16];
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      dwell_r <= '0;
      feedback_fault_trip <= 1'b0;
    end
    else if (!pid_running || !loss)
      dwell_r <= '0;
    else if (dwell_r >= time_r[15:0])
      feedback_fault_trip <= 1'b1; // R13
    else
      dwell_r <= dwell_r + 16'h1; // R13
  end

  // PID gating on remote, enable and run condition
  logic gate;
  always_comb
  begin
    gate = option_active[4] & ~sq.local_panel_flag // R7
           & sq.loop_enable_input; // R9
    if (run_cond == dorpc_pkg::RUN_COND_BOTH)
      gate = gate & sq.run_cmd; // R15 R8
  end
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      pid_running <= 1'b0;
    else
      pid_running <= gate & ~feedback_fault_trip;
  end

  // Drive run state for automatic stop and restart
  logic at_low;
  logic above_hyst;
  assign at_low = pid_output <= limits_r[31:16];
  assign above_hyst = {1'b0, pid_output} >
                      {1'b0, limits_r[31:16]} + {1'b0, setpt_r[31:16]};
  always_comb
  begin
    drv_nxt = drv_r;
    case (drv_r)
      dorpc_pkg::DRV_IDLE:
        if (sq.run_cmd && !run_prev_r && !feedback_fault_trip)
          drv_nxt = dorpc_pkg::DRV_RUN;
      dorpc_pkg::DRV_RUN:
        if (!sq.run_cmd || feedback_fault_trip)
          drv_nxt = dorpc_pkg::DRV_IDLE;
        else if (stop_opt == dorpc_pkg::STOP_AT_LOW && pid_running && at_low)
          drv_nxt = (run_cond == dorpc_pkg::RUN_COND_BOTH)
                    ? dorpc_pkg::DRV_LATCH_STOP // R16 R17
                    : dorpc_pkg::DRV_AUTO_STOP; // R18
      dorpc_pkg::DRV_AUTO_STOP:
        if (!sq.run_cmd)
          drv_nxt = dorpc_pkg::DRV_IDLE; // R18
        else if (above_hyst)
          drv_nxt = dorpc_pkg::DRV_RUN; // R18
      dorpc_pkg::DRV_LATCH_STOP:
        if (!sq.run_cmd)
          drv_nxt = dorpc_pkg::DRV_IDLE; // R17
      default: drv_nxt = dorpc_pkg::DRV_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      drv_r <= dorpc_pkg::DRV_IDLE;
      run_prev_r <= 1'b1;
    end
    else
    begin
      drv_r <= drv_nxt;
      run_prev_r <= sq.run_cmd;
    end
  end
  assign drive_run = drv_r == dorpc_pkg::DRV_RUN;

endmodule

/* test/dorpc_properties.sv */
// Checker: port properties of the option control block
`timescale 1ns/1ps
module dorpc_checker (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Terminals and results
  input wire dorpc_pkg::dorpc_seq_t seq_in,
  input wire logic [7:0] option_active,
  input wire logic pid_running,
  input wire logic drive_run,
  input wire logic feedback_fault_trip
);
  // One domain for every property
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_bus_no_wait: assert property (psel && penable |-> pready)
    else $error("access phase held waiting");
  a_bus_err_map: assert property (psel && penable
    |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h18))
    else $error("bus error flag wrong");
  a_option_onehot: assert property ($onehot(option_active))
    else $error("option enables not one-hot");
  a_local_no_pid: assert property (
    seq_in.local_panel_flag [*8] |-> !pid_running)
    else $error("loop ran in local mode");
  a_enable_gates: assert property (
    !seq_in.loop_enable_input [*8] |-> !pid_running)
    else $error("loop ran without enable");
  a_run_off_stop: assert property (
    !seq_in.run_cmd [*8] |-> !drive_run)
    else $error("drive ran without run command");
  a_fault_sticky: assert property (
    feedback_fault_trip |=> feedback_fault_trip)
    else $error("fault trip cleared");
  a_fault_cause: assert property (
    $rose(feedback_fault_trip) |-> $past(pid_running))
    else $error("fault trip without loop running");
endmodule

bind dorpc_top dorpc_checker i_dorpc_checker (.core_clk, .reset_n,
  .psel, .penable, .paddr, .pready, .pslverr, .seq_in, .option_active,
  .pid_running, .drive_run, .feedback_fault_trip);

/* test/dorpc_terminals.sv */
// Model: sequence terminals and feedback transducer
`timescale 1ns/1ps
module dorpc_terminals (
  // Clock
  input wire logic core_clk,
  // Operator actions
  input wire logic [4:0] step_cmd,
  input wire logic [6:0] seq_cmd,
  input wire logic [15:0] level_cmd,
  // Terminal levels
  output dorpc_pkg::dorpc_steps_t steps_in,
  output dorpc_pkg::dorpc_seq_t seq_in,
  output logic [15:0] feedback_raw,
  output logic [15:0] third_analog_input
);
  // Contacts settle one edge after the operator acts
  always_ff @(posedge core_clk)
  begin
    steps_in <= step_cmd;
    seq_in <= seq_cmd;
    feedback_raw <= level_cmd;
    third_analog_input <= level_cmd >> 1;
  end
endmodule

/* test/drive_option_ramp_pid_control_tb.sv */
// Testbench: bus and terminal checks of the option control block
`timescale 1ns/1ps
module drive_option_ramp_pid_control_tb;
  logic core_clk = 0;
  logic reset_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [4:0] step_cmd = 5'h00;
  logic [6:0] seq_cmd = 7'h00;
  logic [15:0] level_cmd = 16'h3000;
  logic [15:0] pid_output = 16'h0;
  logic [15:0] feedback_raw, third_analog_input;
  logic [15:0] setpoint_pct;
  logic feedback_is_third = 1'b0;
  logic [7:0] option_active;
  logic [1:0] preset_speed_enable_outputs;
  logic signed [16:0] pid_error;
  logic pid_running, drive_run, high_bound_flag, low_bound_flag;
  logic feedback_fault_trip;
  dorpc_pkg::dorpc_steps_t steps_in;
  dorpc_pkg::dorpc_seq_t seq_in;
  dorpc_pkg::dorpc_ramp_t ramp_sel;
  logic [4:0] oh_in [6] = '{5'h04, 5'h00, 5'h11, 5'h13, 5'h18, 5'h10};
  logic [2:0] oh_exp [6] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h7, 3'h7};
  int errors = 0;
  int n_compared = 0;

  // Design and terminal model
  dorpc_top i_dorpc_top (.core_clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .steps_in, .seq_in,
    .feedback_raw, .third_analog_input, .feedback_is_third,
    .pid_output, .option_active, .ramp_sel, .setpoint_pct,
    .pid_error, .pid_running, .drive_run, .high_bound_flag,
    .low_bound_flag, .preset_speed_enable_outputs, .feedback_fault_trip);
  dorpc_terminals i_dorpc_terminals (.core_clk, .step_cmd, .seq_cmd,
    .level_cmd, .steps_in, .seq_in, .feedback_raw, .third_analog_input);

  // Clock
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One bus transfer; answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int k = 0; k < 20; k++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      errors++;
      give_verdict();
    end
    @(posedge core_clk);
  endtask

  // Control word: option, style, run condition, stop option, invert
  function automatic logic [31:0] ctl(input logic [3:0] op,
    input logic [1:0] sty, input logic [1:0] cnd, input logic [1:0] stp,
    input logic inv);
    return {14'h0, 1'b0, inv, stp, cnd, 4'h1, 2'h0, sty, op};
  endfunction

  // Main sequence
  initial
  begin
    hold(4);
    reset_n <= 1'b1;
    hold(5);
    apb(0, 8'h00, 0);
    check(rd, dorpc_pkg::CTRL_RST);
    apb(0, 8'h04, 0);
    check(rd, dorpc_pkg::LIMITS_RST);
    apb(0, 8'h0c, 0);
    check(rd, dorpc_pkg::TIME_RST);
    check(option_active, 8'h01);
    apb(1, 8'h40, 32'h1);
    check(err, 1'b1);
    $display("Test reset done");
    for (int i = 0; i <= 9; i++)
    begin
      apb(1, 8'h00, ctl(i[3:0], 2'h1, 2'h2, 2'h1, 0));
      hold(3);
      check(option_active, (i < 1 || i > 8) ? 1 : 1 << (i - 1));
    end
    $display("Test options done");
    apb(1, 8'h00, ctl(4'h2, 2'h1, 2'h2, 2'h1, 0));
    for (int i = 0; i < 8; i++)
    begin
      step_cmd <= {2'b11, i[2:0]};
      hold(8);
      check(ramp_sel.pair, i[2:0]);
    end
    apb(1, 8'h00, ctl(4'h2, 2'h2, 2'h2, 2'h1, 0));
    for (int i = 0; i < 6; i++)
    begin
      step_cmd <= oh_in[i];
      hold(8);
      check(ramp_sel.pair, oh_exp[i]);
    end
    seq_cmd <= 7'h20;
    hold(8);
    check(ramp_sel.alt_ramp, 1'b1);
    check(ramp_sel.speed_change, 1'b0);
    seq_cmd <= 7'h60;
    hold(8);
    check(ramp_sel.speed_change, 1'b1);
    check(ramp_sel.alt_ramp, 1'b1);
    $display("Test ramps done");
    apb(1, 8'h10, 32'h0100_4000);
    apb(1, 8'h04, 32'h1000_f000);
    apb(1, 8'h00, ctl(4'h5, 2'h1, 2'h2, 2'h1, 0));
    seq_cmd <= 7'h10;
    hold(8);
    check(pid_running, 1'b1);
    check({15'h0, pid_error}, 32'h0_1000);
    apb(1, 8'h00, ctl(4'h5, 2'h1, 2'h2, 2'h1, 1));
    hold(4);
    check({15'h0, pid_error}, 32'h1_f000);
    seq_cmd <= 7'h18;
    hold(8);
    check(pid_running, 1'b0);
    seq_cmd <= 7'h00;
    hold(8);
    check(pid_running, 1'b0);
    apb(1, 8'h00, ctl(4'h5, 2'h1, 2'h1, 2'h1, 0));
    seq_cmd <= 7'h13;
    hold(8);
    check(pid_running, 1'b0);
    $display("Test loop gating done");
    apb(1, 8'h00, ctl(4'h5, 2'h1, 2'h2, 2'h2, 0));
    seq_cmd <= 7'h10;
    pid_output <= 16'h2000;
    hold(8);
    seq_cmd <= 7'h14;
    hold(8);
    check(drive_run, 1'b1);
    pid_output <= 16'h0800;
    hold(8);
    check(drive_run, 1'b0);
    pid_output <= 16'h1080;
    hold(8);
    check(drive_run, 1'b0);
    pid_output <= 16'h1200;
    hold(8);
    check(drive_run, 1'b1);
    $display("Test auto stop done");
    apb(1, 8'h18, {22'h0, 5'h18, 5'h19});
    level_cmd <= 16'hf800;
    hold(8);
    check(preset_speed_enable_outputs, 2'b01);
    check({high_bound_flag, low_bound_flag}, 2'b10);
    apb(1, 8'h08, 32'h0200_1000);
    apb(1, 8'h0c, 32'h10);
    level_cmd <= 16'h0100;
    hold(4);
    check(feedback_fault_trip, 1'b0);
    hold(30);
    check(feedback_fault_trip, 1'b1);
    check({high_bound_flag, low_bound_flag}, 2'b01);
    apb(0, 8'h14, 0);
    check(rd, 32'h0000_0180);
    $display("Test bounds and fault done");
    reset_n <= 1'b0;
    hold(4);
    check(feedback_fault_trip, 1'b0);
    check(option_active, 8'h01);
    reset_n <= 1'b1;
    hold(5);
    apb(1, 8'h00, ctl(4'h5, 2'h1, 2'h1, 2'h2, 0));
    seq_cmd <= 7'h10;
    pid_output <= 16'h2000;
    hold(8);
    seq_cmd <= 7'h14;
    hold(8);
    check(drive_run, 1'b1);
    check(pid_running, 1'b1);
    pid_output <= 16'h0000;
    hold(4);
    check(drive_run, 1'b0);
    pid_output <= 16'h2000;
    hold(8);
    check(drive_run, 1'b0);
    seq_cmd <= 7'h10;
    hold(8);
    seq_cmd <= 7'h14;
    hold(8);
    check(drive_run, 1'b1);
    $display("Test latched stop done");
    apb(1, 8'h10, 32'h0200_0100);
    apb(1, 8'h00, ctl(4'h5, 2'h1, 2'h2, 2'h1, 0) | 32'h2_0000);
    feedback_is_third <= 1'b1;
    hold(4);
    check(setpoint_pct, 16'h7fff);
    check({15'h0, pid_error}, 32'h7f7f);
    apb(1, 8'h00, (ctl(4'h5, 2'h1, 2'h2, 2'h1, 0) | 32'h2_0000) + 32'h100);
    hold(4);
    check({15'h0, pid_error}, 32'h7eff);
    $display("Test scaling done");
    give_verdict();
  end
endmodule
